// [core/ffs_pkg.sv]
// Constants, types and timing of the flyback mode and fault supervisor.
// Assumes a 10 MHz mclk; every analog indication arrives asynchronously.
//
// What this block does
// - Sample output voltage when secondary current ends
// - Pick regime from control level: QR/PFM/fixed/deep
// - Feedback below CV reference enters CC mode
// - Hold primary peak current at switch-off
// - Output current from conduction time times peak
// - Dither switching period around its nominal value
// - Current comparator ignored during turn-on blanking
// - Over-current accepted from blanking end to demag end
// - Three over-current cycles force shutdown and restart
// - Line thresholds sampled only while switch on
// - Line run needed within first three cycles
// - Brown-out after three cycles below stop
// - Three over-voltage samples: fault, shutdown, restart
// - Under-voltage longer than limit: fault and restart
// - Supply over-voltage beyond 110us: fault, shutdown
// - Shutdown faults stop gate, force lockout reset
// - Thermal trip disables the controller
// - Re-enable only after cooling past hysteresis
// - Latched thermal fault cleared at latch release
// - New power-up at turn-on if fault-free
// - First three cycles use minimum peak current
// - Under-voltage check blanked 95 ms after start

package ffs_pkg;

    // ************************************************************
    // Clock and times
    // ************************************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int LEB_NS        = 320;
    localparam int LEB_CYC       = (LEB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int VDD_OVP_US    = 110;
    localparam int VDD_OVP_CYC   = VDD_OVP_US * 1000 / CLK_PERIOD_NS;
    localparam int UVP_TIME_US   = 300;
    localparam int UVP_TIME_CYC  = UVP_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int UVP_BLANK_MS  = 95;
    localparam int UVP_BLANK_CYC = UVP_BLANK_MS * 1000000 / CLK_PERIOD_NS;
    localparam int FIXED_FREQ_HZ = 25000;
    localparam int FIXED_PERIOD_CYC = 1000000000 / (FIXED_FREQ_HZ * CLK_PERIOD_NS);
    localparam int MAX_FREQ_HZ   = 84500;
    localparam int MIN_PERIOD_CYC = (1000000000 + MAX_FREQ_HZ * CLK_PERIOD_NS - 1) / (MAX_FREQ_HZ * CLK_PERIOD_NS);
    localparam int MIN_FREQ_HZ   = 390;
    localparam int DEEP_PERIOD_CYC = 1000000000 / (MIN_FREQ_HZ * CLK_PERIOD_NS);

    // ************************************************************
    // Widths and counts
    // ************************************************************
    localparam int TMR_W    = 20;
    localparam int VAL_W    = 8;
    localparam int TONS_W   = 8;
    localparam int EST_W    = 16;
    localparam int CNT_W    = 2;
    localparam int LEB_W    = 3;
    localparam int VOVP_W   = 11;
    localparam int UVP_W    = 12;
    localparam int DITHER_W = 4;
    localparam int DITHER_SHIFT = 7;
    localparam int PFM_SHIFT    = 2;
    localparam int NUM_CMP  = 15;
    localparam int SYNC_W   = NUM_CMP + 2 * VAL_W;

    localparam logic [CNT_W-1:0]    DEBOUNCE_LAST = 2'h2;
    localparam logic [CNT_W-1:0]    PROBE_N       = 2'h3;
    localparam logic [LEB_W-1:0]    LEB_LAST      = LEB_W'(LEB_CYC);
    localparam logic [VOVP_W-1:0]   VOVP_LAST     = VOVP_W'(VDD_OVP_CYC);
    localparam logic [UVP_W-1:0]    UVP_LAST      = UVP_W'(UVP_TIME_CYC);

    // ************************************************************
    // Control-level thresholds of the regimes
    // ************************************************************
    localparam logic [VAL_W-1:0] COMP_QR_MIN  = 8'hC0;
    localparam logic [VAL_W-1:0] COMP_PFM_MIN = 8'h60;
    localparam logic [VAL_W-1:0] COMP_FIX_MIN = 8'h20;

    typedef enum logic [1:0] {
        RG_QR,
        RG_PFM,
        RG_FIXED,
        RG_DEEP
    } ffs_regime_t;

    typedef enum logic [2:0] {
        ST_WAIT_ON,
        ST_GATE_ON,
        ST_DEMAG,
        ST_OFF_WAIT,
        ST_RESTART_DROP,
        ST_RESTART_RISE,
        ST_THERMAL
    } ffs_state_t;

endpackage

// [core/ffs_sync.sv]
// Two-stage synchroniser for the analog indications.
// Assumes inputs are asynchronous to mclk.

module ffs_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    import ffs_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } ffs_sync_t;

    ffs_sync_t q;
    ffs_sync_t d;

    // ************************************************************
    // Stages
    // ************************************************************
    always_comb begin
        d    = q;
        d.s1 = din;
        d.s2 = q.s1;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign dout = q.s2;

endmodule

// [core/ffs_dither.sv]
// Triangular period dither, one step per switching cycle.
// Assumes step is a one-cycle pulse on mclk.

module ffs_dither (
    input  wire logic                           mclk,
    input  wire logic                           rst_b,
    input  wire logic                           step,
    output logic signed [ffs_pkg::DITHER_W-1:0] offset
);
    import ffs_pkg::*;

    typedef struct packed {
        logic                up;
        logic [DITHER_W-1:0] cnt;
    } ffs_dither_t;

    ffs_dither_t q;
    ffs_dither_t d;

    // ************************************************************
    // Up and down sweep
    // ************************************************************
    always_comb begin
        d = q;
        if (step) begin
            if (q.up) begin
                d.cnt = q.cnt + 4'h1;
                if (q.cnt == 4'hE) begin
                    d.up = 1'b0;
                end
            end else begin
                d.cnt = q.cnt - 4'h1;
                if (q.cnt == 4'h1) begin
                    d.up = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '{up: 1'b1, cnt: 4'h8};
        end else begin
            q <= d;
        end
    end

    // Offset bias flip maps 0..15 onto -8..7
    assign offset = $signed(q.cnt ^ 4'h8);

endmodule

// [core/ffs_supervisor.sv]
// Mode control and fault supervision of a quasi-resonant flyback switch.
// Assumes comparator and sampled inputs from the analog front end,
// all asynchronous; rst_b follows supply lockout release.

module ffs_supervisor #(
    parameter int unsigned UVP_BLANK_CYC   = ffs_pkg::UVP_BLANK_CYC,
    parameter int unsigned DEEP_PERIOD_CYC = ffs_pkg::DEEP_PERIOD_CYC
) (
    input  wire logic                          mclk,
    input  wire logic                          rst_b,
    input  wire logic                          supply_on_cmp,
    input  wire logic                          supply_off_cmp,
    input  wire logic                          latch_release_cmp,
    input  wire logic                          supply_ovp_cmp,
    input  wire logic                          thermal_hot_cmp,
    input  wire logic                          thermal_cool_cmp,
    input  wire logic                          cs_limit_cmp,
    input  wire logic                          overcurrent_cmp,
    input  wire logic                          demag_done_cmp,
    input  wire logic                          valley_cmp,
    input  wire logic                          line_run_cmp,
    input  wire logic                          line_stop_cmp,
    input  wire logic                          vs_ovp_cmp,
    input  wire logic                          vs_uvp_cmp,
    input  wire logic                          vs_below_cv_cmp,
    input  wire logic [ffs_pkg::VAL_W-1:0]     comp_level,
    input  wire logic [ffs_pkg::VAL_W-1:0]     cs_peak_value,
    output logic                               gate_en,
    output logic                               lockout_reset,
    output logic                               min_peak_sel,
    output ffs_pkg::ffs_regime_t               regime,
    output logic                               cc_mode,
    output logic                               vout_sample_strobe,
    output logic      [ffs_pkg::VAL_W-1:0]     peak_hold,
    output logic      [ffs_pkg::EST_W-1:0]     iout_est,
    output logic                               fault_overcurrent,
    output logic                               fault_line,
    output logic                               fault_out_ovp,
    output logic                               fault_out_uvp,
    output logic                               fault_supply_ovp,
    output logic                               fault_thermal
);
    import ffs_pkg::*;

    typedef struct packed {
        ffs_state_t          st;
        logic                gate;
        logic                lock_rst;
        logic                cs_min;
        ffs_regime_t         regime;
        logic                cc;
        logic                vstrobe;
        logic [VAL_W-1:0]    peak;
        logic [EST_W-1:0]    iest;
        logic [TONS_W-1:0]   tons;
        logic [TMR_W-1:0]    tmr;
        logic [LEB_W-1:0]    turn_on_blanking;
        logic                leb_done;
        logic                ocp_seen;
        logic                line_ok;
        logic                line_low;
        logic                run_ok;
        logic                uvp_low;
        logic [CNT_W-1:0]    probe_n;
        logic [CNT_W-1:0]    ocp_n;
        logic [CNT_W-1:0]    ovp_n;
        logic [CNT_W-1:0]    stop_n;
        logic [VOVP_W-1:0]   vovp_t;
        logic [UVP_W-1:0]    uvp_t;
        logic [TMR_W-1:0]    blank_t;
        logic                f_ocp;
        logic                f_line;
        logic                f_ovp;
        logic                f_uvp;
        logic                f_vovp;
        logic                f_otp;
    } ffs_core_t;

    ffs_core_t                   q;
    ffs_core_t                   d;
    logic [SYNC_W-1:0]           syn;
    logic                        s_on;
    logic                        s_off;
    logic                        s_rel;
    logic                        s_vovp;
    logic                        s_hot;
    logic                        s_cool;
    logic                        s_cslim;
    logic                        s_ocp;
    logic                        s_demag;
    logic                        s_valley;
    logic                        s_run;
    logic                        s_stop;
    logic                        s_ovp;
    logic                        s_uvp;
    logic                        s_below;
    logic [VAL_W-1:0]            comp_s;
    logic [VAL_W-1:0]            pk_s;
    logic signed [DITHER_W-1:0]  dofs;
    logic                        begin_cycle;
    logic                        start;
    logic                        trip;
    logic                        running;
    logic [TMR_W-1:0]            period;

    // ************************************************************
    // Input synchronisers and dither
    // ************************************************************
    ffs_sync #(
        .W (SYNC_W)
    ) u_sync (
        .mclk (mclk),
        .rst_b(rst_b),
        .din  ({cs_peak_value, comp_level, vs_below_cv_cmp, vs_uvp_cmp, vs_ovp_cmp,
                line_stop_cmp, line_run_cmp, valley_cmp, demag_done_cmp, overcurrent_cmp,
                cs_limit_cmp, thermal_cool_cmp, thermal_hot_cmp, supply_ovp_cmp,
                latch_release_cmp, supply_off_cmp, supply_on_cmp}),
        .dout (syn)
    );

    assign {pk_s, comp_s, s_below, s_uvp, s_ovp, s_stop, s_run, s_valley, s_demag, s_ocp,
            s_cslim, s_cool, s_hot, s_vovp, s_rel, s_off, s_on} = syn;

    ffs_dither u_dither (
        .mclk  (mclk),
        .rst_b (rst_b),
        .step  (begin_cycle),
        .offset(dofs)
    );

    // ************************************************************
    // Regime and period decoding
    // ************************************************************
    function automatic ffs_regime_t ffs_regime(input logic [VAL_W-1:0] lvl);
        return (lvl >= COMP_QR_MIN) ? RG_QR : (lvl >= COMP_PFM_MIN) ? RG_PFM :
               (lvl >= COMP_FIX_MIN) ? RG_FIXED : RG_DEEP;
    endfunction

    function automatic logic [TMR_W-1:0] ffs_period(input ffs_regime_t r, input logic [VAL_W-1:0] lvl,
                                                    input logic signed [DITHER_W-1:0] ofs);
        logic [TMR_W-1:0]        base;
        logic signed [TMR_W+4:0] adj;
        case (r)
            RG_QR:    base = TMR_W'(MIN_PERIOD_CYC);
            RG_PFM:   base = TMR_W'(MIN_PERIOD_CYC) + TMR_W'({~lvl, {PFM_SHIFT{1'b0}}});
            RG_FIXED: base = TMR_W'(FIXED_PERIOD_CYC);
            default:  base = TMR_W'(DEEP_PERIOD_CYC);
        endcase
        adj = ($signed({5'h00, base}) * $signed({{(TMR_W+1){ofs[DITHER_W-1]}}, ofs})) >>> DITHER_SHIFT;
        return base + adj[TMR_W-1:0];
    endfunction

    assign period  = ffs_period(q.regime, comp_s, dofs);
    assign running = (q.st == ST_GATE_ON) || (q.st == ST_DEMAG) || (q.st == ST_OFF_WAIT);

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_comb begin
        d           = q;
        d.vstrobe   = 1'b0;
        begin_cycle = 1'b0;
        start       = 1'b0;
        trip        = 1'b0;
        case (q.st)
            ST_WAIT_ON: begin
                start = s_on && !s_hot && !s_vovp;
            end
            ST_GATE_ON: begin
                d.tmr     = q.tmr + 1'b1;
                d.line_ok = q.line_ok | s_run;
                d.line_low = s_stop;
                if (!q.leb_done) begin
                    d.turn_on_blanking      = q.turn_on_blanking + 1'b1;
                    d.leb_done = (q.turn_on_blanking + 1'b1) == LEB_LAST;
                end
                if (q.leb_done && s_ocp) begin
                    d.ocp_seen = 1'b1;
                end
                if (q.leb_done && (s_cslim || s_ocp)) begin
                    d.gate = 1'b0;
                    d.peak = pk_s;
                    d.tons = '0;
                    d.st   = ST_DEMAG;
                end
            end
            ST_DEMAG: begin
                d.tmr = q.tmr + 1'b1;
                if (q.tons != '1) begin
                    d.tons = q.tons + 1'b1;
                end
                if (s_ocp) begin
                    d.ocp_seen = 1'b1;
                end
                if (s_demag) begin
                    d.st      = ST_OFF_WAIT;
                    d.vstrobe = 1'b1;
                    d.uvp_low = s_uvp;
                    d.cc      = s_below;
                    d.iest    = EST_W'(q.peak * q.tons);
                    d.regime  = ffs_regime(comp_s);
                    d.ocp_n   = q.ocp_seen ? q.ocp_n + 1'b1 : '0;
                    if (q.ocp_seen && q.ocp_n == DEBOUNCE_LAST) begin
                        d.f_ocp = 1'b1;
                        trip    = 1'b1;
                    end
                    d.ovp_n = s_ovp ? q.ovp_n + 1'b1 : '0;
                    if (s_ovp && q.ovp_n == DEBOUNCE_LAST) begin
                        d.f_ovp = 1'b1;
                        trip    = 1'b1;
                    end
                    if (q.probe_n != PROBE_N) begin
                        d.probe_n = q.probe_n + 1'b1;
                        d.run_ok  = q.run_ok | q.line_ok;
                        if (q.probe_n == DEBOUNCE_LAST && !q.run_ok && !q.line_ok) begin
                            d.f_line = 1'b1;
                            trip     = 1'b1;
                        end
                    end else begin
                        d.stop_n = q.line_low ? q.stop_n + 1'b1 : '0;
                        if (q.line_low && q.stop_n == DEBOUNCE_LAST) begin
                            d.f_line = 1'b1;
                            trip     = 1'b1;
                        end
                    end
                end
            end
            ST_OFF_WAIT: begin
                d.tmr = q.tmr + 1'b1;
                if (q.tmr >= period && (q.regime != RG_QR || s_valley ||
                    q.tmr >= TMR_W'(FIXED_PERIOD_CYC))) begin
                    begin_cycle = 1'b1;
                end
            end
            ST_RESTART_DROP: begin
                if (s_off) begin
                    d.st       = ST_RESTART_RISE;
                    d.lock_rst = 1'b0;
                end
            end
            ST_RESTART_RISE: begin
                start = s_on && !s_hot && !s_vovp;
            end
            ST_THERMAL: begin
                if (s_cool && !s_hot) begin
                    d.st = ST_WAIT_ON;
                end
            end
            default: begin
                d.st = ST_WAIT_ON;
            end
        endcase

        // Timed faults while switching
        if (running) begin
            d.vovp_t = s_vovp ? q.vovp_t + 1'b1 : '0;
            if (s_vovp && q.vovp_t == VOVP_LAST) begin
                d.f_vovp = 1'b1;
                trip     = 1'b1;
            end
            if (q.blank_t != '0) begin
                d.blank_t = q.blank_t - 1'b1;
            end
            d.uvp_t = (q.uvp_low && q.blank_t == '0) ? q.uvp_t + 1'b1 : '0;
            if (q.uvp_low && q.blank_t == '0 && q.uvp_t == UVP_LAST) begin
                d.f_uvp = 1'b1;
                trip    = 1'b1;
            end
        end

        // Fresh power-up
        if (start) begin
            begin_cycle = 1'b1;
            {d.probe_n, d.ocp_n, d.ovp_n, d.stop_n} = '0;
            {d.run_ok, d.uvp_low, d.cc, d.lock_rst} = '0;
            {d.vovp_t, d.uvp_t} = '0;
            d.regime    = RG_QR;
            d.blank_t   = TMR_W'(UVP_BLANK_CYC);
            {d.f_ocp, d.f_line, d.f_ovp, d.f_uvp, d.f_vovp} = '0;
        end
        if (begin_cycle) begin
            d.st       = ST_GATE_ON;
            d.gate     = 1'b1;
            d.tmr      = '0;
            {d.turn_on_blanking, d.leb_done, d.ocp_seen, d.line_ok} = '0;
        end
        if (trip) begin
            d.st       = ST_RESTART_DROP;
            d.gate     = 1'b0;
            d.lock_rst = 1'b1;
        end

        // Thermal disable and latch
        if (s_rel) begin
            d.f_otp = 1'b0;
        end
        if (s_hot) begin
            d.f_otp = 1'b1;
            if (q.st != ST_THERMAL) begin
                d.st   = ST_THERMAL;
                d.gate = 1'b0;
            end
        end
        d.cs_min = d.probe_n != PROBE_N;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            q        <= '0;
            q.cs_min <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign gate_en            = q.gate;
    assign lockout_reset      = q.lock_rst;
    assign min_peak_sel       = q.cs_min;
    assign regime             = q.regime;
    assign cc_mode            = q.cc;
    assign vout_sample_strobe = q.vstrobe;
    assign peak_hold          = q.peak;
    assign iout_est           = q.iest;
    assign fault_overcurrent  = q.f_ocp;
    assign fault_line         = q.f_line;
    assign fault_out_ovp      = q.f_ovp;
    assign fault_out_uvp      = q.f_uvp;
    assign fault_supply_ovp   = q.f_vovp;
    assign fault_thermal      = q.f_otp;

endmodule

// [testbench/ffs_supervisor_chk.sv]
// Port assertions of the flyback supervisor.
// Assumes binding into ffs_supervisor; sees its ports only.
module ffs_supervisor_chk (
    input wire logic                      mclk,
    input wire logic                      rst_b,
    input wire logic                      supply_ovp_cmp,
    input wire logic                      thermal_hot_cmp,
    input wire logic                      gate_en,
    input wire logic                      lockout_reset,
    input wire logic                      min_peak_sel,
    input wire logic                      vout_sample_strobe,
    input wire logic [ffs_pkg::VAL_W-1:0] peak_hold,
    input wire logic                      fault_overcurrent,
    input wire logic                      fault_out_ovp,
    input wire logic                      fault_supply_ovp,
    input wire logic                      fault_thermal
);
    timeunit 1ns;
    timeprecision 1ns;
    import ffs_pkg::*;
    // ****
    // Supply over-voltage run length
    // ****
    logic [10:0] ovp_run_q;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b || !supply_ovp_cmp) begin
            ovp_run_q <= 11'h000;
        end else if (ovp_run_q != 11'h7FF) begin
            ovp_run_q <= ovp_run_q + 11'h001;
        end
    end
    AST_BLANK_HOLD: assert property ($rose(gate_en) |-> (gate_en || lockout_reset || fault_thermal)[*4])
        else $error("gate dropped inside blanking");
    AST_SAMPLE_OFF: assert property (vout_sample_strobe |-> !gate_en ##1 !vout_sample_strobe)
        else $error("output sample taken while on");
    AST_LOCKOUT_OFF: assert property (lockout_reset |-> !gate_en)
        else $error("gate on during lockout");
    AST_THERMAL_OFF: assert property (thermal_hot_cmp [*3] |=> fault_thermal && !gate_en)
        else $error("thermal trip missed");
    AST_OC_SHUT: assert property ($rose(fault_overcurrent) |-> lockout_reset && !gate_en)
        else $error("overcurrent without shutdown");
    AST_OVP_SHUT: assert property ($rose(fault_out_ovp) |-> lockout_reset && !gate_en)
        else $error("output ovp without shutdown");
    AST_PEAK_OFF: assert property (!$stable(peak_hold) |-> !gate_en)
        else $error("peak changed during on time");
    AST_PROBE_END: assert property ($fell(min_peak_sel) |-> vout_sample_strobe)
        else $error("probe ended off a cycle end");
    AST_SUPPLY_OVP: assert property (ovp_run_q == 11'h456 |-> fault_supply_ovp && !gate_en)
        else $error("supply ovp not taken in time");
    cover property ($rose(fault_overcurrent));
    cover property ($rose(fault_thermal));
    cover property ($fell(min_peak_sel));
endmodule
bind ffs_supervisor ffs_supervisor_chk u_chk (.mclk, .rst_b, .supply_ovp_cmp, .thermal_hot_cmp, .gate_en,
    .lockout_reset, .min_peak_sel, .vout_sample_strobe, .peak_hold, .fault_overcurrent, .fault_out_ovp,
    .fault_supply_ovp, .fault_thermal);

// [testbench/ffs_afe.sv]
// Current sense and demagnetisation stand-in.
// Assumes gate_en from the supervisor; moves at falling edges.
module ffs_afe (
    input  wire logic mclk,
    input  wire logic gate_en,
    output logic      cs_limit_cmp,
    output logic      demag_done_cmp,
    output logic      valley_cmp
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] age  = 8'h00;
    logic       last = 1'b0;
    always @(negedge mclk) begin
        age <= (gate_en == last && age != 8'hFF) ? age + 8'h01 : 8'h00;
        last <= gate_en;
    end
    assign cs_limit_cmp = gate_en && age >= 8'h0A;
    assign demag_done_cmp = !gate_en && age >= 8'h14;
    assign valley_cmp = demag_done_cmp && age[3];
endmodule

// [testbench/tb_top.sv]
// Self-checking bench of the flyback supervisor.
// Assumes ffs_afe models the power stage; faults driven here.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import ffs_pkg::*;
    logic mclk, rst_b, supply_on_cmp, supply_off_cmp, latch_release_cmp, supply_ovp_cmp, thermal_hot_cmp;
    logic thermal_cool_cmp, cs_limit_cmp, overcurrent_cmp, demag_done_cmp, valley_cmp, line_run_cmp;
    logic line_stop_cmp, vs_ovp_cmp, vs_uvp_cmp, vs_below_cv_cmp, gate_en, lockout_reset, min_peak_sel;
    logic cc_mode, fault_overcurrent, fault_line, fault_out_ovp, fault_out_uvp, fault_supply_ovp, fault_thermal;
    logic [VAL_W-1:0] comp_level, cs_peak_value, peak_hold;
    logic [EST_W-1:0] iout_est;
    logic [6:0]       st;
    ffs_regime_t      regime;
    int               fails, samples_checked, edges, e0;
    assign st = {lockout_reset, fault_overcurrent, fault_line, fault_out_ovp, fault_out_uvp, fault_supply_ovp,
                 fault_thermal};
    ffs_supervisor #(.UVP_BLANK_CYC(200), .DEEP_PERIOD_CYC(600)) uut (.mclk, .rst_b, .supply_on_cmp,
        .supply_off_cmp, .latch_release_cmp, .supply_ovp_cmp, .thermal_hot_cmp, .thermal_cool_cmp,
        .cs_limit_cmp, .overcurrent_cmp, .demag_done_cmp, .valley_cmp, .line_run_cmp, .line_stop_cmp,
        .vs_ovp_cmp, .vs_uvp_cmp, .vs_below_cv_cmp, .comp_level, .cs_peak_value, .gate_en, .lockout_reset,
        .min_peak_sel, .regime, .cc_mode, .vout_sample_strobe(), .peak_hold, .iout_est, .fault_overcurrent,
        .fault_line, .fault_out_ovp, .fault_out_uvp, .fault_supply_ovp, .fault_thermal);
    ffs_afe afe (.mclk, .gate_en, .cs_limit_cmp, .demag_done_cmp, .valley_cmp);
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge gate_en) edges++;
    task automatic run(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        if (fails == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ****
    // Lockout restart with given line state
    // ****
    task automatic recover(input logic lr);
        {overcurrent_cmp, line_stop_cmp, vs_ovp_cmp, vs_uvp_cmp, supply_ovp_cmp} = 5'h00;
        supply_on_cmp = 1'b0;
        supply_off_cmp = 1'b1;
        run(10);
        chk(16'({gate_en, lockout_reset}), 16'h0000);
        supply_off_cmp = 1'b0;
        line_run_cmp = lr;
        run(50);
        chk(16'(gate_en), 16'h0000);
        supply_on_cmp = 1'b1;
        run(1000);
        chk(16'(st), lr ? 16'h0000 : 16'h0050);
    endtask
    task automatic fault(input int n, input logic [6:0] exp, input logic lr);
        run(n);
        chk(16'({gate_en, st}), 16'(exp));
        recover(lr);
    endtask
    initial begin
        {rst_b, supply_off_cmp, latch_release_cmp, supply_ovp_cmp, thermal_hot_cmp, thermal_cool_cmp} = 6'h00;
        {overcurrent_cmp, line_stop_cmp, vs_ovp_cmp, vs_uvp_cmp, vs_below_cv_cmp} = 5'h00;
        {supply_on_cmp, line_run_cmp, comp_level, cs_peak_value} = {2'h3, 8'hC0, 8'h5A};
        run(2);
        chk(16'({gate_en, min_peak_sel}), 16'h0001);
        rst_b = 1'b1;
        run(1000);
        chk(16'({min_peak_sel, st}), 16'h0000);
        chk(16'(peak_hold), 16'h005A);
        chk(iout_est, 16'h07BC);
        for (int i = 0; i < 4; i++) begin
            comp_level = i[1:0] == 2'h0 ? 8'hC0 : i[1:0] == 2'h1 ? 8'h60 : i[1:0] == 2'h2 ? 8'h20 : 8'h00;
            run(2500);
            chk(16'(regime), 16'(i));
        end
        vs_below_cv_cmp = 1'b1;
        run(1500);
        chk(16'(cc_mode), 16'h0001);
        {vs_below_cv_cmp, comp_level} = {1'b0, 8'hC0};
        run(1500);
        chk(16'(cc_mode), 16'h0000);
        overcurrent_cmp = 1'b1;
        fault(1500, 7'h60, 1'b1);
        line_stop_cmp = 1'b1;
        fault(1500, 7'h50, 1'b0);
        fault(1, 7'h50, 1'b1);
        vs_ovp_cmp = 1'b1;
        fault(1500, 7'h48, 1'b1);
        vs_uvp_cmp = 1'b1;
        fault(4000, 7'h44, 1'b1);
        supply_ovp_cmp = 1'b1;
        run(1090);
        chk(16'(st), 16'h0000);
        fault(100, 7'h42, 1'b1);
        thermal_hot_cmp = 1'b1;
        run(10);
        e0 = edges;
        run(500);
        chk(16'({gate_en, st, edges != e0}), 16'h0002);
        thermal_hot_cmp = 1'b0;
        run(500);
        chk(16'(edges != e0), 16'h0000);
        thermal_cool_cmp = 1'b1;
        run(1000);
        chk(16'({st, edges != e0}), 16'h0003);
        latch_release_cmp = 1'b1;
        run(10);
        chk(16'(fault_thermal), 16'h0000);
        finish_test();
    end
    initial begin
        #(100 * 80000);
        fails++;
        finish_test();
    end
endmodule
